// ==== urx_pkg.sv ====
// constants, field layout and carrier types of the serial receive path
package urx_pkg;
	// timing: bit time of both shifters, in clock cycles
	localparam int URX_CLK_NS = 10;
	localparam int URX_BIT_NS = 160;
	localparam int URX_OSR = URX_BIT_NS / URX_CLK_NS;
	localparam logic [3:0] URX_BIT_LAST = 4'(URX_OSR - 1);
	localparam logic [3:0] URX_BIT_MID = 4'(URX_OSR / 2 - 1);
	localparam logic [2:0] URX_DEPTH = 3'h4;
	// register offsets (adr[3:0] of the bus)
	localparam logic [3:0] URX_CTRL_OFS = 4'h0;
	localparam logic [3:0] URX_STAT_OFS = 4'h4;
	localparam logic [3:0] URX_DATA_OFS = 4'h8;
	// control register fields
	localparam int URX_C_RXEN = 0;
	localparam int URX_C_TXEN = 1;
	localparam int URX_C_LEN = 2;
	localparam int URX_C_OSH = 5;
	localparam int URX_C_MAT = 6;
	localparam int URX_C_MBIT = 8;
	localparam int URX_C_ITS = 9;
	localparam int URX_C_HDX = 10;
	localparam int URX_C_LB = 11;
	localparam int URX_C_IRTX = 13;
	localparam int URX_C_IRRX = 14;
	localparam int URX_C_PW = 15;
	localparam int URX_C_INV = 17;
	localparam int URX_C_THR = 18;
	localparam logic [31:0] URX_CTRL_MASK = 32'h000F_FFFF;
	localparam logic [31:0] URX_CTRL_RST = 32'h0000_000C;
	// status register fields
	localparam int URX_S_CNT = 0;
	localparam int URX_S_REQ = 4;
	localparam int URX_S_RBSY = 5;
	localparam int URX_S_TBSY = 6;
	localparam int URX_S_OVR = 8;
	localparam int URX_S_FRM = 9;
	localparam int URX_S_FER = 10;
	localparam int URX_S_FLUSH = 15;
	// length and match codes
	localparam logic [2:0] URX_LEN_9N = 3'h4;
	localparam logic [2:0] URX_LEN_9F = 3'h5;
	localparam logic [1:0] URX_MAT_ADDR = 2'h1;
	localparam logic [1:0] URX_MAT_FRAME = 2'h2;
	localparam logic [1:0] URX_MAT_STORE = 2'h3;
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [3:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} urx_wb_req_t;
	typedef struct packed {
		logic ack;
		logic [31:0] dat;
	} urx_wb_rsp_t;
	typedef struct packed {
		logic tx;
		logic oe;
	} urx_pin_t;
	typedef enum logic [1:0] {URX_IDLE, URX_START, URX_DATA, URX_STOP} urx_state_t;
endpackage : urx_pkg

// ==== urx_top.sv ====
// serial receive path with fifo, match modes, irda, duplex and loop back
module urx_top (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire urx_pkg::urx_wb_req_t wb_i,
	output urx_pkg::urx_wb_rsp_t wb_o,
	input wire logic rx_i,
	output urx_pkg::urx_pin_t tx_o
);
	import urx_pkg::*;

	// data bits per frame from the length code
	function automatic logic [3:0] len_bits(input logic [2:0] c);
		len_bits = (c < URX_LEN_9N) ? 4'({1'b0, c}) + 4'h5 : 4'h9;
	endfunction : len_bits

	// fifo entries popped by a read of the given byte lanes
	function automatic logic [2:0] pop_need(input logic [3:0] s,
		input logic [2:0] c);
		unique case (s)
			4'h1: pop_need = 3'h1;
			4'h3: pop_need = (c == URX_LEN_9N) ? 3'h1 : 3'h2;
			4'hF: pop_need = (c == URX_LEN_9N) ? 3'h2 : 3'h4;
			default: pop_need = 3'h0;
		endcase
	endfunction : pop_need

	// threshold code to entry count
	function automatic logic [2:0] thr_n(input logic [1:0] t);
		unique case (t)
			2'h0: thr_n = 3'h1;
			2'h1: thr_n = 3'h2;
			default: thr_n = 3'h4;
		endcase
	endfunction : thr_n

	logic [31:0] ctrl_q, ctrl_d;
	urx_wb_rsp_t rsp_q, rsp_d;
	logic [8:0] mem_q [4];
	logic [8:0] mem_d [4];
	logic [1:0] rd_q, rd_d, wr_q, wr_d;
	logic [2:0] cnt_q, cnt_d;
	logic [8:0] hold_q, hold_d;
	logic hold_v_q, hold_v_d;
	logic req_q, req_d, ovr_q, ovr_d, frm_q, frm_d, fer_q, fer_d;
	logic [8:0] tdat_q, tdat_d;
	logic tpend_q, tpend_d;
	logic [2:0] len, need, pop;
	logic [1:0] mat;
	logic mbit, hdx, req, rd_ok, rd_bad, ctrl_wr, flush, acc;
	logic [8:0] entry;
	logic [3:0] nb;
	logic [2:0] smp_q, smp_d;
	logic dg_q, dg_d, rx_line;
	logic [3:0] ir_q, ir_d;
	urx_state_t st_q, st_d;
	logic [3:0] tmr_q, tmr_d, idx_q, idx_d;
	logic [8:0] sh_q, sh_d, rx_algn;
	logic rx_done, rx_last, rx_busy;
	logic tbusy_q, tbusy_d, txl_q, txl_d, tx_start;
	logic [3:0] ttm_q, ttm_d, tcnt_q, tcnt_d;
	logic [10:0] tsh_q, tsh_d;
	urx_pin_t pin_q, pin_d;

	assign len = ctrl_q[URX_C_LEN +: 3];
	assign mat = ctrl_q[URX_C_MAT +: 2];
	assign mbit = ctrl_q[URX_C_MBIT];
	assign hdx = ctrl_q[URX_C_HDX];
	assign nb = len_bits(len);
	assign rx_busy = st_q != URX_IDLE;
	assign wb_o = rsp_q;
	assign tx_o = pin_q;

	// rx front end: source select, majority de-glitch, irda demodulation
	always_comb begin
		smp_d = {smp_q[1:0], ctrl_q[URX_C_LB] ? txl_q : rx_i};
		dg_d = (smp_q[0] & smp_q[1]) | (smp_q[1] & smp_q[2])
			| (smp_q[0] & smp_q[2]);
		ir_d = ir_q;
		if (!dg_q) begin
			ir_d = URX_BIT_LAST;
		end else if (ir_q != 4'h0) begin
			ir_d = ir_q - 4'h1;
		end
		rx_line = ctrl_q[URX_C_IRRX] ? (dg_q & (ir_q == 4'h0)) : dg_q;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			smp_q <= 3'h7;
			dg_q <= 1'h1;
			ir_q <= 4'h0;
		end else begin
			smp_q <= smp_d;
			dg_q <= dg_d;
			ir_q <= ir_d;
		end
	end

	// receive shifter: start at half bit, data bits, stop
	always_comb begin
		st_d = st_q;
		tmr_d = tmr_q + 4'h1;
		idx_d = idx_q;
		sh_d = sh_q;
		rx_done = 1'h0;
		unique case (st_q)
			URX_IDLE: begin
				tmr_d = 4'h0;
				if (ctrl_q[URX_C_RXEN] && !rx_line
					&& !(hdx && tbusy_q)) begin
					st_d = URX_START;
				end
			end
			URX_START: begin
				if (tmr_q == URX_BIT_MID) begin
					tmr_d = 4'h0;
					idx_d = 4'h0;
					st_d = rx_line ? URX_IDLE : URX_DATA;
				end
			end
			URX_DATA: begin
				if (tmr_q == URX_BIT_LAST) begin
					tmr_d = 4'h0;
					sh_d = {rx_line, sh_q[8:1]};
					idx_d = idx_q + 4'h1;
					if (idx_q == nb - 4'h1) begin
						st_d = URX_STOP;
					end
				end
			end
			URX_STOP: begin
				if (tmr_q == URX_BIT_LAST) begin
					rx_done = 1'h1;
					st_d = URX_IDLE;
				end
			end
		endcase
		if (flush && st_q == URX_IDLE) begin
			sh_d = 9'h000;
		end
		rx_algn = sh_q >> (4'h9 - nb);
		rx_last = rx_algn[nb - 4'h1];
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q <= URX_IDLE;
			tmr_q <= 4'h0;
			idx_q <= 4'h0;
			sh_q <= 9'h000;
		end else begin
			st_q <= st_d;
			tmr_q <= tmr_d;
			idx_q <= idx_d;
			sh_q <= sh_d;
		end
	end

	// bus slave, control, flags and receive fifo
	always_comb begin
		req = wb_i.cyc && wb_i.stb && !rsp_q.ack;
		need = pop_need(wb_i.sel, len);
		rd_ok = need != 3'h0 && need <= cnt_q;
		rd_bad = req && !wb_i.we && wb_i.adr == URX_DATA_OFS && !rd_ok;
		pop = (req && !wb_i.we && wb_i.adr == URX_DATA_OFS && rd_ok)
			? need : 3'h0;
		ctrl_wr = req && wb_i.we && wb_i.adr == URX_CTRL_OFS;
		flush = req && wb_i.we && wb_i.adr == URX_STAT_OFS
			&& wb_i.sel[1] && wb_i.dat[URX_S_FLUSH];
		acc = rx_done && (mat != URX_MAT_ADDR || rx_last == mbit);
		entry = (len == URX_LEN_9F) ? {1'h0, rx_algn[7:0]}
			: rx_algn;
		rsp_d.ack = req;
		rsp_d.dat = 32'h0000_0000;
		ctrl_d = ctrl_q;
		for (int b = 0; b < 4; b++) begin
			if (ctrl_wr && wb_i.sel[b]) begin
				ctrl_d[8*b +: 8] = wb_i.dat[8*b +: 8];
			end
		end
		ctrl_d = ctrl_d & URX_CTRL_MASK;
		ovr_d = ovr_q;
		frm_d = frm_q;
		fer_d = fer_q;
		if (req && wb_i.we && wb_i.adr == URX_STAT_OFS && wb_i.sel[1]) begin
			ovr_d = ovr_q & ~wb_i.dat[URX_S_OVR];
			frm_d = frm_q & ~wb_i.dat[URX_S_FRM];
			fer_d = fer_q & ~wb_i.dat[URX_S_FER];
		end
		tdat_d = tdat_q;
		tpend_d = tpend_q && !tx_start;
		if (req && wb_i.we && wb_i.adr == URX_DATA_OFS && !tpend_q
			&& ctrl_q[URX_C_TXEN]) begin
			tdat_d = wb_i.dat[8:0];
			tpend_d = 1'h1;
		end
		// read data assembly
		unique case (wb_i.adr)
			URX_CTRL_OFS: rsp_d.dat = ctrl_q;
			URX_STAT_OFS: begin
				rsp_d.dat[URX_S_CNT +: 3] = cnt_q;
				rsp_d.dat[URX_S_REQ] = req_q;
				rsp_d.dat[URX_S_RBSY] = rx_busy;
				rsp_d.dat[URX_S_TBSY] = tbusy_q;
				rsp_d.dat[URX_S_OVR] = ovr_q;
				rsp_d.dat[URX_S_FRM] = frm_q;
				rsp_d.dat[URX_S_FER] = fer_q;
			end
			URX_DATA_OFS: begin
				for (int k = 0; k < 4; k++) begin
					if (3'(k) < pop) begin
						if (len == URX_LEN_9N) begin
							rsp_d.dat[(k % 2) * 16 +: 9] =
								mem_q[rd_q + 2'(k)];
						end else begin
							rsp_d.dat[8*k +: 8] = mem_q[rd_q + 2'(k)][7:0];
						end
					end
				end
			end
			default: rsp_d.dat = 32'h0000_0000;
		endcase
		if (!wb_i.we || !req) begin
			rsp_d.dat = req ? rsp_d.dat : rsp_q.dat;
		end else begin
			rsp_d.dat = 32'h0000_0000;
		end
		// fifo: pop, drain shifter, then take the new frame
		mem_d = mem_q;
		rd_d = rd_q + pop[1:0];
		wr_d = wr_q;
		cnt_d = cnt_q - pop;
		hold_d = hold_q;
		hold_v_d = hold_v_q;
		if (hold_v_q && cnt_d < URX_DEPTH) begin
			mem_d[wr_d] = hold_q;
			wr_d = wr_d + 2'h1;
			cnt_d = cnt_d + 3'h1;
			hold_v_d = 1'h0;
		end
		if (acc) begin
			if (hold_v_d) begin
				hold_d = entry;
				ovr_d = 1'h1;
			end else if (cnt_d < URX_DEPTH) begin
				mem_d[wr_d] = entry;
				wr_d = wr_d + 2'h1;
				cnt_d = cnt_d + 3'h1;
			end else begin
				hold_d = entry;
				hold_v_d = 1'h1;
			end
			if (ctrl_q[URX_C_OSH]) begin
				ctrl_d[URX_C_OSH] = 1'h0;
				ctrl_d[URX_C_RXEN] = 1'h0;
			end
			if (st_q == URX_STOP && !rx_line) begin
				frm_d = 1'h1;
			end
		end
		if (rx_done) begin
			unique case (mat)
				URX_MAT_ADDR: if (rx_last == mbit) begin
					ctrl_d[URX_C_MAT +: 2] = URX_MAT_FRAME;
				end
				URX_MAT_FRAME: if (rx_last == mbit) begin
					frm_d = 1'h1;
				end
				URX_MAT_STORE: ctrl_d[URX_C_MBIT] = rx_last;
				default: ctrl_d[URX_C_MAT +: 2] = ctrl_d[URX_C_MAT +: 2];
			endcase
		end
		if (flush) begin
			rd_d = wr_d;
			cnt_d = 3'h0;
			if (!rx_busy) begin
				hold_v_d = 1'h0;
			end
		end
		if (rd_bad) begin
			fer_d = 1'h1;
		end
		req_d = cnt_d >= thr_n(ctrl_d[URX_C_THR +: 2]);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_q <= URX_CTRL_RST;
			rsp_q <= '0;
			mem_q <= '{default: 9'h000};
			rd_q <= 2'h0;
			wr_q <= 2'h0;
			cnt_q <= 3'h0;
			hold_q <= 9'h000;
			hold_v_q <= 1'h0;
			req_q <= 1'h0;
			ovr_q <= 1'h0;
			frm_q <= 1'h0;
			fer_q <= 1'h0;
			tdat_q <= 9'h000;
			tpend_q <= 1'h0;
		end else begin
			ctrl_q <= ctrl_d;
			rsp_q <= rsp_d;
			mem_q <= mem_d;
			rd_q <= rd_d;
			wr_q <= wr_d;
			cnt_q <= cnt_d;
			hold_q <= hold_d;
			hold_v_q <= hold_v_d;
			req_q <= req_d;
			ovr_q <= ovr_d;
			frm_q <= frm_d;
			fer_q <= fer_d;
			tdat_q <= tdat_d;
			tpend_q <= tpend_d;
		end
	end

	// transmit shifter, irda modulation and pin drive
	always_comb begin
		tx_start = tpend_q && !tbusy_q && !(hdx && rx_busy);
		tbusy_d = tbusy_q;
		ttm_d = ttm_q;
		tcnt_d = tcnt_q;
		tsh_d = tsh_q;
		if (tx_start) begin
			tbusy_d = 1'h1;
			ttm_d = 4'h0;
			tcnt_d = nb + 4'h2;
			tsh_d = {1'h0, (tdat_q & ~(9'h1FF << nb)), 1'h0}
				| (11'h001 << (nb + 4'h1));
		end else if (tbusy_q) begin
			ttm_d = ttm_q + 4'h1;
			if (ttm_q == URX_BIT_LAST) begin
				ttm_d = 4'h0;
				tsh_d = {1'h1, tsh_q[10:1]};
				tcnt_d = tcnt_q - 4'h1;
				tbusy_d = tcnt_q != 4'h1;
			end
		end
		txl_d = 1'h1;
		if (tbusy_q) begin
			txl_d = ctrl_q[URX_C_IRTX]
				? !(!tsh_q[0] && ttm_q <= 4'({2'h0, ctrl_q[URX_C_PW +: 2]}))
				: tsh_q[0];
		end
		pin_d.tx = ctrl_q[URX_C_LB + 1] ? rx_i
			: txl_q ^ ctrl_q[URX_C_INV];
		pin_d.oe = ctrl_q[URX_C_LB + 1]
			|| !(ctrl_q[URX_C_ITS] && !tbusy_q);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tbusy_q <= 1'h0;
			ttm_q <= 4'h0;
			tcnt_q <= 4'h0;
			tsh_q <= 11'h7FF;
			txl_q <= 1'h1;
			pin_q <= '{tx: 1'h1, oe: 1'h1};
		end else begin
			tbusy_q <= tbusy_d;
			ttm_q <= ttm_d;
			tcnt_q <= tcnt_d;
			tsh_q <= tsh_d;
			txl_q <= txl_d;
			pin_q <= pin_d;
		end
	end

	// checks next to the logic
	sequence frame_begin_s;
		st_q == URX_IDLE ##1 st_q == URX_START;
	endsequence
	busy_in_frame_a: assert property (@(posedge clk_i) disable iff (rst_i)
		frame_begin_s |-> (st_q != URX_IDLE)[*8])
		else $error("receive busy dropped inside a frame");
	fill_count_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!flush && !hold_v_q && acc && cnt_q < URX_DEPTH && pop == 3'h0
		|=> cnt_q == $past(cnt_q) + 3'h1)
		else $error("fill count missed a push");
	req_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
		req_q == (cnt_q >= thr_n(ctrl_q[URX_C_THR +: 2])))
		else $error("request flag disagrees with fill count");
	overrun_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
		acc && hold_v_q && cnt_q == URX_DEPTH && pop == 3'h0 |=> ovr_q)
		else $error("overrun not flagged");
	addr_switch_a: assert property (@(posedge clk_i) disable iff (rst_i)
		rx_done && !ctrl_wr && mat == URX_MAT_ADDR && rx_last == mbit
		|=> ctrl_q[URX_C_MAT +: 2] == URX_MAT_FRAME)
		else $error("match did not switch to frame mode");
	one_shot_a: assert property (@(posedge clk_i) disable iff (rst_i)
		rx_done && !ctrl_wr && ctrl_q[URX_C_OSH] |=> ctrl_q[URX_C_OSH] == !$past(acc))
		else $error("one-shot bit handled wrongly");
	flush_empty_a: assert property (@(posedge clk_i) disable iff (rst_i)
		flush |=> cnt_q == 3'h0 ##1 !req_q || cnt_q != 3'h0)
		else $error("flush left entries");
	empty_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
		rd_bad |=> fer_q && rsp_q.ack && rsp_q.dat == 32'h0000_0000)
		else $error("bad read not flagged");
	idle_release_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ctrl_q[URX_C_ITS] && !ctrl_q[URX_C_LB + 1] && !tbusy_q
		&& $stable(ctrl_q) |=> !pin_q.oe)
		else $error("tx pin driven while idle");
	duplex_block_a: assert property (@(posedge clk_i) disable iff (rst_i)
		hdx && rx_busy && !tbusy_q |=> !tbusy_q)
		else $error("transmit started during reception");
endmodule : urx_top

// ==== urx_node.sv ====
// remote serial node: sends frames on rx and resolves the shared tx line
module urx_node (
	input wire logic clk_i,
	input wire urx_pkg::urx_pin_t tx_i,
	output logic rx_o,
	output logic line_o
);
	timeunit 1ns;
	timeprecision 1ps;
	import urx_pkg::*;
	// board pull-up holds the line high when the pin is released
	assign line_o = tx_i.oe ? tx_i.tx : 1'b1;
	initial begin
		rx_o = 1'b1;
	end
	// one frame: start, n data bits lsb first, one stop; start and data 16 cycles each, stop 20
	task automatic send(input logic [8:0] d, input int n);
		int i;
		@(posedge clk_i) rx_o <= 1'b0;
		repeat (URX_OSR) @(posedge clk_i);
		for (i = 0; i < n; i++) begin
			rx_o <= d[i];
			repeat (URX_OSR) @(posedge clk_i);
		end
		rx_o <= 1'b1;
		repeat (URX_OSR + 4) @(posedge clk_i);
	endtask : send
	// infrared frame: a zero bit is a three-cycle low pulse, a one none
	task automatic send_ir(input logic [8:0] d, input int n);
		int i;
		logic b;
		for (i = 0; i < n + 2; i++) begin
			b = (i == 0) ? 1'b0 : (i > n) ? 1'b1 : d[i - 1];
			@(posedge clk_i) rx_o <= b;
			repeat (3) @(posedge clk_i);
			rx_o <= 1'b1;
			repeat (URX_OSR - 4) @(posedge clk_i);
		end
		repeat (4) @(posedge clk_i);
	endtask : send_ir
endmodule : urx_node

// ==== test_urx_top.sv ====
// self-checking bench of the serial receive path
module test_urx_top;
	timeunit 1ns;
	timeprecision 1ps;
	import urx_pkg::*;
	logic clk_i;
	logic rst_i;
	urx_wb_req_t wb_i;
	urx_wb_rsp_t wb_o;
	logic rx_i;
	logic line;
	urx_pin_t tx_o;
	int num_errors;
	int compares;
	logic [31:0] r;
	urx_top urx_top_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i),
		.wb_o(wb_o), .rx_i(rx_i), .tx_o(tx_o));
	urx_node urx_node_inst (.clk_i(clk_i), .tx_i(tx_o), .rx_o(rx_i),
		.line_o(line));
	// clock generator
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	task automatic conclude();
		if (num_errors == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : conclude
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// one classic wishbone cycle, held until ack is sampled
	task automatic wb(input logic we, input logic [3:0] a,
		input logic [3:0] s, input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk_i);
		wb_i <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: s, dat: d};
		do begin
			@(posedge clk_i);
			n++;
			if (n > 100) begin
				num_errors++;
				conclude();
			end
		end while (wb_o.ack !== 1'b1);
		q = wb_o.dat;
		wb_i <= '0;
	endtask : wb
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, a, 4'hF, d, q);
	endtask : wr
	task automatic rc(input logic [3:0] a, input logic [3:0] s,
		input logic [31:0] e);
		logic [31:0] q;
		wb(1'b0, a, s, 32'h0, q);
		chk(q, e);
	endtask : rc
	// watchdog
	initial begin
		repeat (50000) @(posedge clk_i);
		num_errors++;
		conclude();
	end
	// test sequence
	initial begin
		num_errors = 0;
		compares = 0;
		wb_i = '0;
		rst_i = 1'b1;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		rc(URX_CTRL_OFS, 4'hF, 32'h0000_000C);
		rc(URX_STAT_OFS, 4'hF, 32'h0000_0000);
		rc(4'hC, 4'hF, 32'h0000_0000);
		// empty fifo read flags an error, then clear it
		rc(URX_DATA_OFS, 4'h1, 32'h0000_0000);
		rc(URX_STAT_OFS, 4'hF, 32'h0000_0400);
		wr(URX_STAT_OFS, 32'h0000_0400);
		// two bytes, threshold of two, busy seen mid frame
		wr(URX_CTRL_OFS, 32'h0004_000D);
		fork
			urx_node_inst.send(9'h0A5, 8);
			begin
				repeat (60) @(posedge clk_i);
				wb(1'b0, URX_STAT_OFS, 4'hF, 32'h0, r);
				chk({31'h0, r[URX_S_RBSY]}, 32'h1);
			end
		join
		rc(URX_STAT_OFS, 4'hF, 32'h0000_0001);
		urx_node_inst.send(9'h03C, 8);
		rc(URX_STAT_OFS, 4'hF, 32'h0000_0012);
		rc(URX_DATA_OFS, 4'h3, 32'h0000_3CA5);
		rc(URX_STAT_OFS, 4'hF, 32'h0000_0000);
		// six frames: fifo full, shifter overwritten
		for (int i = 1; i <= 6; i++) begin
			urx_node_inst.send(9'(i * 17), 8);
		end
		rc(URX_STAT_OFS, 4'hF, 32'h0000_0114);
		rc(URX_DATA_OFS, 4'hF, 32'h4433_2211);
		rc(URX_STAT_OFS, 4'hF, 32'h0000_0101);
		wr(URX_STAT_OFS, 32'h0000_8000);
		rc(URX_STAT_OFS, 4'hF, 32'h0000_0100);
		wr(URX_STAT_OFS, 32'h0000_0700);
		// normal nine-bit mode, word read of two entries
		wr(URX_CTRL_OFS, 32'h0000_0011);
		urx_node_inst.send(9'h1A5, 9);
		urx_node_inst.send(9'h0F0, 9);
		rc(URX_DATA_OFS, 4'hF, 32'h00F0_01A5);
		// fixed nine-bit: low eight stored
		wr(URX_CTRL_OFS, 32'h0000_0015);
		urx_node_inst.send(9'h15A, 9);
		rc(URX_DATA_OFS, 4'h1, 32'h0000_005A);
		// address mode with one-shot: mismatch dropped, match switches
		wr(URX_CTRL_OFS, 32'h0000_016D);
		urx_node_inst.send(9'h055, 8);
		rc(URX_STAT_OFS, 4'hF, 32'h0000_0000);
		rc(URX_CTRL_OFS, 4'hF, 32'h0000_016D);
		urx_node_inst.send(9'h0AA, 8);
		rc(URX_CTRL_OFS, 4'hF, 32'h0000_018C);
		rc(URX_DATA_OFS, 4'h1, 32'h0000_00AA);
		// frame mode: matching last bit flags a frame error
		wr(URX_CTRL_OFS, 32'h0000_018D);
		urx_node_inst.send(9'h080, 8);
		rc(URX_STAT_OFS, 4'hF, 32'h0000_0211);
		rc(URX_DATA_OFS, 4'h1, 32'h0000_0080);
		wr(URX_STAT_OFS, 32'h0000_0700);
		// store mode copies last bit into the match bit
		wr(URX_CTRL_OFS, 32'h0000_00CD);
		urx_node_inst.send(9'h080, 8);
		rc(URX_CTRL_OFS, 4'hF, 32'h0000_01CD);
		rc(URX_DATA_OFS, 4'h1, 32'h0000_0080);
		// receiver fed from the transmitter
		wr(URX_CTRL_OFS, 32'h0000_080F);
		wr(URX_DATA_OFS, 32'h0000_005A);
		repeat (220) @(posedge clk_i);
		rc(URX_DATA_OFS, 4'h1, 32'h0000_005A);
		// receive pin echoed to the transmit pin
		wr(URX_CTRL_OFS, 32'h0000_100C);
		fork
			urx_node_inst.send(9'h000, 8);
			begin
				repeat (40) @(posedge clk_i);
				chk({30'h0, tx_o.oe, line}, 32'h2);
			end
		join
		// five-bit frames, threshold of four not reached by one entry
		wr(URX_CTRL_OFS, 32'h0008_0001);
		urx_node_inst.send(9'h015, 5);
		rc(URX_STAT_OFS, 4'hF, 32'h0000_0001);
		rc(URX_DATA_OFS, 4'h1, 32'h0000_0015);
		// infrared receive: short low pulses decoded to plain bits
		wr(URX_CTRL_OFS, 32'h0000_400D);
		urx_node_inst.send_ir(9'h05A, 8);
		rc(URX_DATA_OFS, 4'h1, 32'h0000_005A);
		// infrared transmit: zero bits give a quarter-bit low pulse
		wr(URX_CTRL_OFS, 32'h0001_A00E);
		wr(URX_DATA_OFS, 32'h0000_0000);
		repeat (6) @(posedge clk_i);
		chk({31'h0, tx_o.tx}, 32'h0);
		@(posedge clk_i);
		chk({31'h0, tx_o.tx}, 32'h1);
		repeat (170) @(posedge clk_i);
		// half duplex: looped frame ignored while sending
		wr(URX_CTRL_OFS, 32'h0000_0C0F);
		wr(URX_DATA_OFS, 32'h0000_005A);
		repeat (220) @(posedge clk_i);
		wb(1'b0, URX_STAT_OFS, 4'hF, 32'h0, r);
		chk({29'h0, r[URX_S_CNT +: 3]}, 32'h0);
		// half duplex: transmit waits for the reception to end
		wr(URX_CTRL_OFS, 32'h0000_040F);
		fork
			urx_node_inst.send(9'h033, 8);
			begin
				repeat (40) @(posedge clk_i);
				wr(URX_DATA_OFS, 32'h0000_0011);
				wb(1'b0, URX_STAT_OFS, 4'hF, 32'h0, r);
				chk({31'h0, r[URX_S_TBSY]}, 32'h0);
			end
		join
		rc(URX_DATA_OFS, 4'h1, 32'h0000_0033);
		repeat (200) @(posedge clk_i);
		// idle tristate releases the pin, pull-up holds idle
		wr(URX_CTRL_OFS, 32'h0000_020C);
		repeat (5) @(posedge clk_i);
		chk({30'h0, tx_o.oe, line}, 32'h1);
		// inverted transmitter idles low
		wr(URX_CTRL_OFS, 32'h0002_000C);
		repeat (5) @(posedge clk_i);
		chk({31'h0, tx_o.tx}, 32'h0);
		conclude();
	end
endmodule : test_urx_top
